// File: bgw_cfg.svh
// register map, field positions, reset values and timing counts
`ifndef BGW_CFG_SVH
`define BGW_CFG_SVH

// ==================================================================
// register offsets (byte addresses, one word each)
`define BGW_CONFIG_OFS      8'h00
`define BGW_IRQ_STATUS_OFS  8'h04
`define BGW_IRQ_MASK_OFS    8'h08
`define BGW_FRAME_TIME_OFS  8'h0c
`define BGW_GAP_COUNT_OFS   8'h10

// ==================================================================
// option bit positions in the config register
`define BGW_GAP_EN_BIT      5
`define BGW_WDOG_EN_BIT     4
`define BGW_SYNC_SRC_BIT    3
`define BGW_FORCE_EVEN_BIT  2

// interrupt bit positions (status and mask share the layout)
`define BGW_IRQ_WDOG_BIT    0
`define BGW_IRQ_LAUNCH_BIT  1

// message control word bit selecting the counter as sync source
`define BGW_CTRL_SYNC_CTR_BIT 15

// ==================================================================
// reset values
`define BGW_CONFIG_RST      6'h00
`define BGW_IRQ_RST         2'h0

// ==================================================================
// timing: one microsecond tick from the 25 ns clock
`define BGW_CLK_PERIOD_NS   25
`define BGW_USEC_NS         1000
`define BGW_USEC_CYCLES     (`BGW_USEC_NS / `BGW_CLK_PERIOD_NS)

`endif

// File: bgw_pkg.sv
// types shared by the gap, watchdog and sync option logic
package bgw_pkg;

  // ================================================================
  // message pacing states, gray coded along idle -> run -> wait
  typedef enum logic [1:0] {
    BGW_GAP_IDLE = 2'b00,
    BGW_GAP_RUN  = 2'b01,
    BGW_GAP_WAIT = 2'b11
  } bgw_gap_state_type;

  // ================================================================
  // whole state of the top module
  typedef struct packed {
    logic [5:0]        usecDiv;
    logic              wrPend;
    logic [7:0]        wrAddr;
    logic [31:0]       rdData;
    logic [5:0]        optBits;
    logic [1:0]        irqStatus;
    logic [1:0]        irqMask;
    bgw_gap_state_type gapState;
    logic              gapExpired;
    logic              launch;
    logic              syncValid;
    logic              syncStore;
    logic [15:0]       syncWord;
  } bgw_top_state_type;

  // whole state of one microsecond countdown
  typedef struct packed {
    logic [15:0] count;
  } bgw_timer_state_type;

endpackage : bgw_pkg

// File: bgw_timer_if.sv
// signals between the control logic and one microsecond countdown
`timescale 1ns/1ps
interface bgw_timer_if;
  logic        load;
  logic [15:0] loadValue;
  logic        tick;
  logic [15:0] count;
  logic        zero;

  modport ctl (output load, output loadValue, output tick, input count, input zero);
  modport tmr (input load, input loadValue, input tick, output count, output zero);
endinterface : bgw_timer_if

// File: bgw_usec_timer.sv
// loadable countdown stepping once per microsecond tick
`timescale 1ns/1ps
module bgw_usec_timer
  import bgw_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  bgw_timer_if.tmr  tif
);

  bgw_timer_state_type stateReg;
  bgw_timer_state_type stateNext;

  // ================================================================
  // countdown: load wins over a tick in the same cycle
  always_comb begin
    stateNext = stateReg;
    if (tif.load) begin
      stateNext.count = tif.loadValue;
    end else if (tif.tick && (stateReg.count != 16'h0000)) begin
      stateNext.count = stateReg.count - 16'h0001;
    end
  end

  // pulse on the step from one to zero only, not while resting at zero
  assign tif.zero  = tif.tick && !tif.load && (stateReg.count == 16'h0001);
  assign tif.count = stateReg.count;

  // ================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

endmodule : bgw_usec_timer

// File: bgw_option_ctrl.sv
// message gap pacing, frame watchdog and sync word source options
//
// Summary of operation
// - gap timer off: no added delay between messages
// - gap timer on: countdown decrements every microsecond
// - next message starts when countdown steps one-to-zero
// - gap already elapsed: launch right after completion
// - watchdog on and enabled: flag on frame one-to-zero
// - source option affects only sync-with-data command
// - option on, bit 15 clear: word from data block
// - option on, bit 15 set: send and store counter
// - option off: word always from data block
// - force-even clears counter word least significant bit
// - force-even clear: counter word sent unaltered
//
// register map, one word each; unmapped offsets read as zero
//   0x00 option bits: 5 gap timer, 4 watchdog, 3 sync source, 2 even word
//   0x04 interrupt status, write one to clear: 0 watchdog, 1 launched
//   0x08 interrupt mask, same layout; bit 0 also arms the watchdog
//   0x0c frame time: a write loads the countdown, a read gives the count
//   0x10 gap count: read only, the running countdown
// the slave never inserts wait states; read data is fetched in the
// address phase and stands in a flop for the whole data phase
`timescale 1ns/1ps
`include "bgw_cfg.svh"
module bgw_option_ctrl
  import bgw_pkg::*;
#(
  // clocks per microsecond; the 6-bit divider caps it at 64
  parameter int unsigned USEC_CYCLES = `BGW_USEC_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  // AHB-Lite register slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq,
  // message sequencer side
  input  wire logic        msgStart,
  input  wire logic [15:0] msgGapTime,
  input  wire logic        msgDone,
  output logic             launchNext,
  input  wire logic        frameTimeLoad,
  input  wire logic [15:0] frameTimeValue,
  // synchronize-with-data word selection
  input  wire logic        syncReq,
  input  wire logic        syncModeCode,
  input  wire logic [15:0] ctrlWord,
  input  wire logic [15:0] ramSyncWord,
  input  wire logic [31:0] timeBase,
  output logic             syncWordValid,
  output logic [15:0]      syncWord,
  output logic             syncWriteBack
);

  localparam logic [5:0] USEC_LAST = 6'(USEC_CYCLES - 1);

  // whole state of the block as one packed struct
  bgw_top_state_type stateReg;
  bgw_top_state_type stateNext;

  // the gap and frame microsecond countdowns
  bgw_timer_if gapTif ();
  bgw_timer_if frameTif ();

  // decoded enables and interrupt event vectors
  logic        usecTick;
  logic        addrPhase;
  logic        busFrameWr;
  logic        statusWr;
  logic        gapEnable;
  logic        wdogEnable;
  logic        fromCounter;
  logic [1:0]  irqSet;
  logic [1:0]  irqClr;

  // ================================================================
  // helpers

  // read value of one register offset; unmapped offsets read zero
  function automatic logic [31:0] regRead(input logic [7:0]        ofs,
                                          input bgw_top_state_type s,
                                          input logic [15:0]       gapCount,
                                          input logic [15:0]       frameCount);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (ofs)
      `BGW_CONFIG_OFS:     v = {26'h0000000, s.optBits[5:2], 2'b00};
      `BGW_IRQ_STATUS_OFS: v = {30'h00000000, s.irqStatus};
      `BGW_IRQ_MASK_OFS:   v = {30'h00000000, s.irqMask};
      `BGW_FRAME_TIME_OFS: v = {16'h0000, frameCount};
      `BGW_GAP_COUNT_OFS:  v = {16'h0000, gapCount};
      default:             v = 32'h0000_0000;
    endcase
    return v;
  endfunction : regRead

  // word for the sync command, counter or data block, even if asked
  function automatic logic [15:0] pickSyncWord(input logic        useCounter,
                                               input logic        forceEven,
                                               input logic [15:0] counterLow,
                                               input logic [15:0] blockWord);
    logic [15:0] w;
    w = blockWord;
    if (useCounter) begin
      w = counterLow;
      if (forceEven) begin
        w[0] = 1'b0;
      end
    end
    return w;
  endfunction : pickSyncWord

  // a pending data phase write that targets one register offset
  function automatic logic wrHits(input bgw_top_state_type s,
                                  input logic [7:0]        ofs);
    return s.wrPend && (s.wrAddr == ofs);
  endfunction : wrHits

  // ================================================================
  // bus decode and shared enables
  assign addrPhase  = hsel && hready && htrans[1];
  assign busFrameWr = wrHits(stateReg, `BGW_FRAME_TIME_OFS);
  assign statusWr   = wrHits(stateReg, `BGW_IRQ_STATUS_OFS);
  assign gapEnable  = stateReg.optBits[`BGW_GAP_EN_BIT];
  assign wdogEnable = stateReg.optBits[`BGW_WDOG_EN_BIT];
  // free-running divider: the first microsecond after a load is cut
  // short by its phase, so a gap of N lasts N-1 to N microseconds
  assign usecTick   = (stateReg.usecDiv == USEC_LAST);

  // only the sync-with-data command may take the counter
  assign fromCounter = syncModeCode
                       && stateReg.optBits[`BGW_SYNC_SRC_BIT]
                       && ctrlWord[`BGW_CTRL_SYNC_CTR_BIT];

  // ================================================================
  // countdown wiring: gap loaded per message, frame by reload
  assign gapTif.load        = msgStart && gapEnable;
  assign gapTif.loadValue   = msgGapTime;
  assign gapTif.tick        = usecTick && gapEnable;
  // a bus write of the frame time has priority over a sequencer reload
  assign frameTif.load      = busFrameWr || frameTimeLoad;
  assign frameTif.loadValue = busFrameWr ? hwdata[15:0] : frameTimeValue;
  // the frame count runs whether or not the watchdog is armed
  assign frameTif.tick      = usecTick;

  bgw_usec_timer gapTimer (
    .clk    (clk),
    .resetn (resetn),
    .tif    (gapTif)
  );

  bgw_usec_timer frameTimer (
    .clk    (clk),
    .resetn (resetn),
    .tif    (frameTif)
  );

  // ================================================================
  // interrupt events and write-one-to-clear requests
  always_comb begin
    irqSet = 2'b00;
    irqClr = 2'b00;
    // the mask doubles as the watchdog interrupt enable
    irqSet[`BGW_IRQ_WDOG_BIT] = frameTif.zero && wdogEnable
                                && stateReg.irqMask[`BGW_IRQ_WDOG_BIT];
    // every launch pulse is an event of its own
    irqSet[`BGW_IRQ_LAUNCH_BIT] = stateReg.launch;
    if (statusWr) begin
      irqClr = hwdata[1:0];
    end
  end

  // ================================================================
  // next-state logic
  always_comb begin
    stateNext           = stateReg;
    stateNext.launch    = 1'b0;
    stateNext.syncValid = 1'b0;
    stateNext.syncStore = 1'b0;

    // microsecond divider
    stateNext.usecDiv = usecTick ? 6'h00 : stateReg.usecDiv + 6'h01;

    // bus data phase write
    stateNext.wrPend = 1'b0;
    if (stateReg.wrPend) begin
      case (stateReg.wrAddr)
        `BGW_CONFIG_OFS:   stateNext.optBits = {hwdata[5:2], 2'b00};
        `BGW_IRQ_MASK_OFS: stateNext.irqMask = hwdata[1:0];
        // status clears and frame loads act through irqClr and the timer
        default:           stateNext.optBits = stateReg.optBits;
      endcase
    end

    // bus address phase; read data is fetched here so it sits in a flop
    if (addrPhase) begin
      stateNext.wrPend = hwrite;
      stateNext.wrAddr = haddr[7:0];
      if (!hwrite) begin
        stateNext.rdData = regRead(haddr[7:0], stateReg, gapTif.count, frameTif.count);
      end
    end

    // set wins over a clear in the same cycle
    stateNext.irqStatus = (stateReg.irqStatus & ~irqClr) | irqSet;

    // gap elapsed tracking; a zero gap counts as elapsed at once
    if (msgStart) begin
      stateNext.gapExpired = (msgGapTime == 16'h0000);
    end else if (gapTif.zero) begin
      stateNext.gapExpired = 1'b1;
    end

    // message pacing
    case (stateReg.gapState)
      BGW_GAP_IDLE: begin
        // a completion with no message running is ignored
        if (msgStart) begin
          stateNext.gapState = BGW_GAP_RUN;
        end
      end
      BGW_GAP_RUN: begin
        if (msgDone) begin
          if (!gapEnable) begin
            stateNext.launch   = 1'b1;
            stateNext.gapState = BGW_GAP_IDLE;
          end else if (stateReg.gapExpired || gapTif.zero) begin
            stateNext.launch   = 1'b1;
            stateNext.gapState = BGW_GAP_IDLE;
          end else begin
            stateNext.gapState = BGW_GAP_WAIT;
          end
        end
      end
      BGW_GAP_WAIT: begin
        if (msgStart) begin
          // a message started early takes over with its own gap
          stateNext.gapState = BGW_GAP_RUN;
        end else if (gapTif.zero || !gapEnable) begin
          // dropping the enable mid-wait releases the message too
          stateNext.launch   = 1'b1;
          stateNext.gapState = BGW_GAP_IDLE;
        end
      end
      default: begin
        stateNext.gapState = BGW_GAP_IDLE;
      end
    endcase

    // sync word selection, answered one cycle after the request
    if (syncReq) begin
      stateNext.syncValid = 1'b1;
      stateNext.syncStore = fromCounter;
      stateNext.syncWord  = pickSyncWord(fromCounter,
                                         stateReg.optBits[`BGW_FORCE_EVEN_BIT],
                                         timeBase[15:0], ramSyncWord);
    end
  end

  // ================================================================
  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stateReg           <= '0;
      stateReg.optBits   <= `BGW_CONFIG_RST;
      stateReg.irqStatus <= `BGW_IRQ_RST;
      stateReg.irqMask   <= `BGW_IRQ_RST;
      stateReg.gapState  <= BGW_GAP_IDLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ================================================================
  // bus response; zero wait states, so the slave is always ready
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = stateReg.rdData;

  // level interrupt, high while any unmasked status bit stands
  assign irq           = |(stateReg.irqStatus & stateReg.irqMask);

  // launch pulse to the sequencer, straight from its flop
  assign launchNext    = stateReg.launch;

  // sync answer; the word holds until the next request is answered
  assign syncWordValid = stateReg.syncValid;
  assign syncWord      = stateReg.syncWord;
  assign syncWriteBack = stateReg.syncStore;

endmodule : bgw_option_ctrl

// File: bgw_option_ctrl_sva.sv
// assertion checker for the option control ports
`timescale 1ns/1ps
module bgw_option_ctrl_sva (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        msgStart,
  input wire logic        launchNext,
  input wire logic        irq,
  input wire logic        syncReq,
  input wire logic        syncModeCode,
  input wire logic [15:0] ctrlWord,
  input wire logic [15:0] ramSyncWord,
  input wire logic [31:0] timeBase,
  input wire logic        syncWordValid,
  input wire logic [15:0] syncWord,
  input wire logic        syncWriteBack
);
  // ================================================================
  // sync word answers, one clock domain only
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_sync_answer: assert property (
    syncReq |=> syncWordValid) else $error("sync answer missing");
  a_sync_quiet: assert property (
    !syncReq |=> !syncWordValid && !syncWriteBack) else $error("sync answer unasked");
  a_other_cmd: assert property (
    syncReq && !syncModeCode |=> syncWord == $past(ramSyncWord) && !syncWriteBack)
    else $error("other command altered");
  a_block_word: assert property (
    syncReq && !ctrlWord[15] |=> syncWord == $past(ramSyncWord)) else $error("block word lost");
  a_store_sent: assert property (
    syncWriteBack |-> syncWordValid && syncWord[15:1] == $past(timeBase[15:1]))
    else $error("counter word wrong");
  a_counter_cause: assert property (
    syncWriteBack |-> $past(syncReq && syncModeCode && ctrlWord[15]))
    else $error("counter used without cause");
  // ================================================================
  // message launch pulses, and cover points for launch, store and interrupt
  a_launch_pulse: assert property (
    launchNext |=> !launchNext) else $error("launch longer than a cycle");
  a_no_early_launch: assert property (
    msgStart |=> !launchNext) else $error("launch beside message start");
  c_launch: cover property (launchNext);
  c_store: cover property (syncWriteBack);
  c_irq: cover property ($rose(irq));
endmodule : bgw_option_ctrl_sva
bind bgw_option_ctrl bgw_option_ctrl_sva u_sva (.clk(clk), .resetn(resetn),
  .msgStart(msgStart), .launchNext(launchNext), .irq(irq), .syncReq(syncReq),
  .syncModeCode(syncModeCode), .ctrlWord(ctrlWord), .ramSyncWord(ramSyncWord),
  .timeBase(timeBase), .syncWordValid(syncWordValid), .syncWord(syncWord),
  .syncWriteBack(syncWriteBack));

// File: bgw_seq_model.sv
// message sequencer model: starts a message, reports it done later
`timescale 1ns/1ps
module bgw_seq_model (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        go,
  input wire logic [15:0] gapUs,
  input wire logic [15:0] busy,
  output logic            msgStart,
  output logic [15:0]     msgGapTime,
  output logic            msgDone
);
  logic [15:0] cnt;
  // ================================================================
  // done always follows start, never before, as the order demands
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      msgStart <= 1'b0;
      msgDone <= 1'b0;
      cnt <= 16'h0;
      msgGapTime <= 16'h0;
    end else begin
      msgStart <= go;
      msgGapTime <= go ? gapUs : ~msgGapTime; // stale value flips to its complement every cycle
      cnt <= go ? busy : (cnt != 16'h0 ? cnt - 16'h1 : 16'h0);
      msgDone <= (cnt == 16'h1);
    end
  end
endmodule : bgw_seq_model

// File: bgw_option_ctrl_tb.sv
// self-checking bench for the option control block
`timescale 1ns/1ps
module bgw_option_ctrl_tb;
  logic clk = 0, resetn = 0, hsel = 0, hwrite = 0, go = 0, frameTimeLoad = 0;
  logic syncReq = 0, syncModeCode = 0, hreadyout, hresp, irq, launchNext;
  logic syncWordValid, syncWriteBack, msgStart, msgDone, c;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, timeBase = 32'h0, hrdata, rd;
  logic [15:0] ctrlWord = 16'h0, ramSyncWord = 16'h0, frameTimeValue = 16'h0;
  logic [15:0] gapUs = 16'h0, busy = 16'h0, syncWord, msgGapTime;
  int error_cnt = 0, checks = 0, n;
  always #12.5 clk = ~clk;
  bgw_option_ctrl dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .msgStart(msgStart),
    .msgGapTime(msgGapTime), .msgDone(msgDone), .launchNext(launchNext),
    .frameTimeLoad(frameTimeLoad), .frameTimeValue(frameTimeValue), .syncReq(syncReq),
    .syncModeCode(syncModeCode), .ctrlWord(ctrlWord), .ramSyncWord(ramSyncWord),
    .timeBase(timeBase), .syncWordValid(syncWordValid), .syncWord(syncWord),
    .syncWriteBack(syncWriteBack));
  bgw_seq_model u_seq (.clk(clk), .resetn(resetn), .go(go), .gapUs(gapUs), .busy(busy),
    .msgStart(msgStart), .msgGapTime(msgGapTime), .msgDone(msgDone));
  // ================================================================
  // shared tasks
  task stop_test;
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task chk_rng(input int v, input int lo, input int hi);
    chk(32'(v >= lo && v <= hi), 32'h1);
  endtask : chk_rng
  // one single word transfer; address held until hready is seen high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask : bus
  // counts cycles from the request to the launch pulse
  task run_msg(input logic [15:0] g, input logic [15:0] b);
    gapUs <= g; busy <= b; go <= 1'b1; n = 0;
    do begin @(posedge clk); go <= 1'b0; #1; n++; end
    while (launchNext !== 1'b1 && n < 400);
    @(posedge clk);
  endtask : run_msg
  // ================================================================
  // scenarios
  task test_regs;
    bus(0, 8'h00, 0); chk(rd, 32'h0);
    bus(1, 8'h00, 32'h3c); bus(0, 8'h00, 0); chk(rd, 32'h3c);
    bus(1, 8'h10, 32'hffff); bus(0, 8'h10, 0); chk(rd, 32'h0);
    bus(0, 8'h20, 0); chk(rd, 32'h0);
  endtask : test_regs
  task test_msgs;
    bus(1, 8'h00, 32'h0); run_msg(16'h32, 16'h6); chk_rng(n, 8, 10);
    bus(1, 8'h00, 32'h20); run_msg(16'h2, 16'h6); chk_rng(n, 42, 86);
    run_msg(16'h1, 16'h64); chk_rng(n, 102, 104);
    bus(0, 8'h04, 0); chk(rd, 32'h2);
    bus(1, 8'h04, 32'h3); bus(0, 8'h04, 0); chk(rd, 32'h0);
  endtask : test_msgs
  task test_wdog;
    bus(1, 8'h08, 32'h1); bus(1, 8'h00, 32'h10);
    frameTimeLoad <= 1'b1; frameTimeValue <= 16'h2;
    n = 0;
    do begin @(posedge clk); frameTimeLoad <= 1'b0; #1; n++; end
    while (irq !== 1'b1 && n < 200);
    @(posedge clk); chk_rng(n, 40, 125);
    bus(0, 8'h04, 0); chk(rd, 32'h1);
    bus(1, 8'h04, 32'h1); bus(0, 8'h04, 0); chk(rd, 32'h0);
    chk(irq, 1'b0);
    bus(1, 8'h08, 32'h0); bus(1, 8'h0c, 32'h1);
    repeat (100) @(posedge clk);
    bus(0, 8'h04, 0); chk(rd, 32'h0);
    bus(1, 8'h08, 32'h1); bus(1, 8'h00, 32'h0); bus(1, 8'h0c, 32'h1);
    repeat (100) @(posedge clk);
    chk(irq, 1'b0);
    bus(0, 8'h04, 0); chk(rd, 32'h0);
  endtask : test_wdog
  task test_sync;
    for (int i = 0; i < 16; i++) begin
      bus(1, 8'h00, {28'h0, i[2], i[0], 2'h0});
      syncModeCode <= i[3]; ctrlWord <= {i[1], 15'h0}; syncReq <= 1'b1;
      timeBase <= 32'h12345677; ramSyncWord <= 16'hbeef;
      @(posedge clk); syncReq <= 1'b0; #1;
      c = i[3] & i[2] & i[1];
      chk(syncWordValid, 1'b1);
      chk(syncWord, c ? (i[0] ? 16'h5676 : 16'h5677) : 16'hbeef);
      chk(syncWriteBack, c);
      @(posedge clk);
    end
  endtask : test_sync
  // ================================================================
  // main sequence and hang guard
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    test_regs; test_msgs; test_wdog; test_sync;
    stop_test;
  end
  initial begin
    #(25 * 10000);
    error_cnt++;
    stop_test;
  end
endmodule : bgw_option_ctrl_tb
